//--- hdl/icp_pkg.sv
// package: register offsets, field positions, modes and sizes for the capture pair
package icp_pkg;
  localparam int DW = 16;
  localparam int FIFO_DEPTH = 4;
  localparam int PTR_W = 2;
  localparam int CNT_W = 3;
  // register offsets (word index on the plain port)
  localparam logic [2:0] OFS_ODD_CTRL1 = 3'h0;
  localparam logic [2:0] OFS_ODD_CTRL2 = 3'h1;
  localparam logic [2:0] OFS_ODD_BUF   = 3'h2;
  localparam logic [2:0] OFS_EVEN_CTRL1 = 3'h4;
  localparam logic [2:0] OFS_EVEN_CTRL2 = 3'h5;
  localparam logic [2:0] OFS_EVEN_BUF   = 3'h6;
  // control one fields
  localparam int C1_MODE_LO = 0;
  localparam int C1_BNE     = 3;
  localparam int C1_IFREQ_LO = 5;
  localparam int C1_TSEL_LO = 10;
  // control two fields
  localparam int C2_SSEL_LO = 0;
  localparam int C2_TSTAT   = 6;
  localparam int C2_TRIG    = 7;
  localparam int C2_CASC    = 8;
  // writable masks
  localparam logic [15:0] C1_WMASK = 16'h1C67;
  localparam logic [15:0] C2_WMASK = 16'h01DF;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [4:0]  SSEL_NONE = 5'h00;
  localparam logic [3:0]  PRE4_LAST = 4'h3;
  localparam logic [3:0]  PRE16_LAST = 4'hF;
  localparam logic [1:0]  IFREQ_ONE = 2'h0;
  typedef enum logic [2:0] {
    ICP_OFF   = 3'h0,
    ICP_EVERY = 3'h1,
    ICP_RISE  = 3'h3,
    ICP_FALL  = 3'h2,
    ICP_PRE4  = 3'h4,
    ICP_PRE16 = 3'h5
  } icp_mode_t;
  // state of one module: holding in reset, armed (waiting trigger), running
  typedef enum logic [1:0] {
    ICP_HOLD = 2'b00,
    ICP_ARM  = 2'b01,
    ICP_RUN  = 2'b11
  } icp_state_t;
endpackage

//--- hdl/icp_fifo.sv
// capture buffer: small flip-flop FIFO with pop on buffer read
`timescale 1ns/1ps
module icp_fifo
  import icp_pkg::*;
(
  // clock and reset
  input  wire logic                  mclk_i,
  input  wire logic                  rst_n_i,
  // control
  input  wire logic                  flush_i,
  input  wire logic                  push_i,
  input  wire logic [icp_pkg::DW-1:0] data_i,
  input  wire logic                  pop_i,
  // status
  output logic [icp_pkg::DW-1:0]      head_o,
  output logic                       not_empty_o
);
  logic [DW-1:0]    mem_q [FIFO_DEPTH];
  logic [PTR_W-1:0] wr_q;
  logic [PTR_W-1:0] rd_q;
  logic [CNT_W-1:0] cnt_q;
  logic             do_push;
  logic             do_pop;

  // a full buffer drops new captures; the oldest values are kept
  assign do_pop  = pop_i && (cnt_q != '0);
  assign do_push = push_i && (cnt_q != CNT_W'(FIFO_DEPTH) || do_pop);

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else if (flush_i) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (do_push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (do_pop) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q <= cnt_q + CNT_W'(do_push) - CNT_W'(do_pop);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (do_push) begin
      mem_q[wr_q] <= data_i;
    end
  end

  assign head_o      = (cnt_q != '0) ? mem_q[rd_q] : '0;
  assign not_empty_o = (cnt_q != '0);
endmodule

//--- hdl/icp_edge.sv
// edge qualifier: edge detect plus 4/16 rising-edge prescaler
`timescale 1ns/1ps
module icp_edge
  import icp_pkg::*;
(
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       rst_n_i,
  // control
  input  wire logic       run_i,
  input  wire logic [2:0] mode_i,
  input  wire logic       pin_i,
  // event
  output logic            event_o
);
  logic       pin_q;
  logic [3:0] pre_q;
  logic       rise;
  logic       fall;

  assign rise = pin_i && !pin_q;
  assign fall = !pin_i && pin_q;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= pin_i;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pre_q <= '0;
    end else if (!run_i) begin
      pre_q <= '0;
    end else if (rise) begin
      pre_q <= pre_q + 1'b1;
    end
  end

  always_comb begin
    event_o = 1'b0;
    if (run_i) begin
      case (mode_i)
        ICP_EVERY: event_o = rise || fall; // R5
        ICP_RISE:  event_o = rise; // R5 R6
        ICP_FALL:  event_o = fall;
        ICP_PRE4:  event_o = rise && (pre_q[1:0] == PRE4_LAST[1:0]); // R6
        ICP_PRE16: event_o = rise && (pre_q == PRE16_LAST); // R6
        default:   event_o = 1'b0;
      endcase
    end
  end
endmodule

//--- hdl/icp_top.sv
// input capture pair: odd/even modules, 16-bit each or cascaded 32-bit
// What this block does
// R1 - out of reset, modules capture independently, 16-bit
// R2 - cascade: odd low half, even high half
// R3 - odd counter wrap increments even counter
// R4 - cascade needs enable bit in both modules
// R5 - capture on rising edges or every transition
// R6 - capture every, 4th or 16th rising edge
// R7 - interrupt frequency field decimates interrupts independently
// R8 - not-empty flag set while FIFO holds data
// R9 - software drains buffer before configuring
// R10 - software picks nonzero sync source for sync/trigger
// R11 - software sets time base before enabling
// R12 - trigger bit selects sync or trigger; status clears
// R13 - software sets mode last of settings
// R14 - software enables sync source as last step
// R15 - software writes even cascade bit first
// R16 - pair gets identical time base and sync settings
// R17 - even with trigger clear follows odd module
// R18 - odd module fields govern cascaded unit
// R19 - cascaded sync: both held until source enabled
// R20 - capture only once mode is on and source enabled
// R21 - 32-bit read: odd low word, even high word
// R22 - captured value is count at qualified edge
`timescale 1ns/1ps
module icp_top
  import icp_pkg::*;
(
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  // register port
  input  wire logic [2:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic [15:0]      rdata_o,
  // time base clock enables, one bit per time base select code
  input  wire logic [7:0]  tb_tick_i,
  // sync/trigger sources, bit n is source n (bit 0 unused)
  input  wire logic [31:0] sync_src_i,
  // capture pins
  input  wire logic        cap_odd_i,
  input  wire logic        cap_even_i,
  // interrupt requests, one-cycle pulses
  output logic             irq_odd_o,
  output logic             irq_even_o
);
  import icp_pkg::*;

  logic [15:0] c1_q [2];
  logic [15:0] c2_q [2];
  logic [DW-1:0] cnt_q [2];
  icp_state_t    st_q [2];
  logic [1:0]    icnt_q [2];
  logic [1:0]    rd_ev;
  logic [1:0]    wr_c1;
  logic [1:0]    wr_c2;
  logic [1:0]    hit;
  logic [1:0]    ev;
  logic [1:0]    push;
  logic [1:0]    bne;
  logic [1:0]    tick;
  logic [1:0]    src_on;
  logic [1:0]    run;
  logic [1:0]    hold;
  logic [1:0]    trig_hit;
  logic [DW-1:0] head [2];
  logic [DW-1:0] fifo_d [2];
  logic [2:0]    mode_eff [2];
  logic [1:0]    ifreq [2];
  logic          casc;
  logic          odd_wrap;

  function automatic logic [4:0] f_ssel(input logic [15:0] c2);
    return c2[C2_SSEL_LO +: 5];
  endfunction

  function automatic logic [2:0] f_mode(input logic [15:0] c1);
    return c1[C1_MODE_LO +: 3];
  endfunction

  // codes 6 and 7 are unassigned and leave the module off like code 0
  function automatic logic f_on(input logic [2:0] md);
    return (md >= ICP_EVERY) && (md <= ICP_PRE16);
  endfunction

  function automatic logic [1:0] f_ifreq(input logic [15:0] c1);
    return c1[C1_IFREQ_LO +: 2];
  endfunction

  // index 0 is the odd module, index 1 the even module
  assign wr_c1 = {wr_i && addr_i == OFS_EVEN_CTRL1, wr_i && addr_i == OFS_ODD_CTRL1};
  assign wr_c2 = {wr_i && addr_i == OFS_EVEN_CTRL2, wr_i && addr_i == OFS_ODD_CTRL2};
  assign rd_ev = {rd_i && addr_i == OFS_EVEN_BUF, rd_i && addr_i == OFS_ODD_BUF};

  assign casc = c2_q[0][C2_CASC] && c2_q[1][C2_CASC]; // R4

  // per-module time base tick and source status
  always_comb begin
    for (int m = 0; m < 2; m++) begin
      tick[m]   = tb_tick_i[c1_q[m][C1_TSEL_LO +: 3]];
      src_on[m] = (f_ssel(c2_q[m]) != SSEL_NONE) && sync_src_i[f_ssel(c2_q[m])];
    end
  end

  // in cascade the odd module's mode governs both halves
  assign mode_eff[0] = f_mode(c1_q[0]);
  assign mode_eff[1] = casc ? f_mode(c1_q[0]) : f_mode(c1_q[1]); // R18
  assign ifreq[0]    = f_ifreq(c1_q[0]);
  assign ifreq[1]    = casc ? f_ifreq(c1_q[0]) : f_ifreq(c1_q[1]); // R7 R18

  // sync: hold in reset while source off; trigger: wait for source then latch
  always_comb begin
    for (int m = 0; m < 2; m++) begin
      hold[m] = !f_on(mode_eff[m]) || !src_on[m]; // R20
      trig_hit[m] = src_on[m];
    end
    if (casc) begin
      hold[1] = hold[0]; // R17 R19
    end
  end

  // a mode write never restarts a running module; only mode off, or a lost source with the trigger bit clear, does
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q[0] <= ICP_HOLD;
      st_q[1] <= ICP_HOLD;
    end else begin
      for (int m = 0; m < 2; m++) begin
        case (st_q[m])
          ICP_HOLD: begin
            if (f_on(mode_eff[m])) begin
              st_q[m] <= ICP_ARM;
            end
          end
          ICP_ARM: begin
            if (!f_on(mode_eff[m])) begin
              st_q[m] <= ICP_HOLD;
            end else if (!hold[m]) begin
              st_q[m] <= ICP_RUN; // R20
            end
          end
          ICP_RUN: begin
            if (!f_on(mode_eff[m])) begin
              st_q[m] <= ICP_HOLD;
            end else if (!c2_q[m][C2_TRIG] && hold[m]) begin
              st_q[m] <= ICP_ARM; // R12 R19
            end
          end
          default: st_q[m] <= ICP_HOLD;
        endcase
      end
      if (casc) begin
        st_q[1] <= st_q[0]; // R17
      end
    end
  end

  assign run[0] = (st_q[0] == ICP_RUN);
  assign run[1] = casc ? run[0] : (st_q[1] == ICP_RUN);

  // counters: 16-bit each, even one counts odd wraps in cascade
  // wrap is seen one cycle early so both halves step on the same edge
  assign odd_wrap = run[0] && tick[0] && (cnt_q[0] == '1);

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q[0] <= '0;
    end else if (!run[0]) begin
      cnt_q[0] <= '0;
    end else if (tick[0]) begin
      cnt_q[0] <= cnt_q[0] + 1'b1; // R1
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q[1] <= '0;
    end else if (!run[1]) begin
      cnt_q[1] <= '0;
    end else if (casc ? odd_wrap : tick[1]) begin
      cnt_q[1] <= cnt_q[1] + 1'b1; // R2 R3
    end
  end

  // control registers; trigger status is set by hardware, set wins
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      c1_q[0] <= CTRL_RST;
      c1_q[1] <= CTRL_RST;
      c2_q[0] <= CTRL_RST;
      c2_q[1] <= CTRL_RST;
    end else begin
      for (int m = 0; m < 2; m++) begin
        if (wr_c1[m]) begin
          c1_q[m] <= wdata_i & C1_WMASK;
        end
        if (wr_c2[m]) begin
          c2_q[m] <= wdata_i & C2_WMASK;
        end
        if (c2_q[m][C2_TRIG] && trig_hit[m] && st_q[m] != ICP_HOLD) begin
          c2_q[m][C2_TSTAT] <= 1'b1; // R12
        end
      end
    end
  end

  // edge qualifiers
  icp_edge u_edge_odd (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .run_i   (run[0]),
    .mode_i  (mode_eff[0]),
    .pin_i   (cap_odd_i),
    .event_o (hit[0])
  );

  icp_edge u_edge_even (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .run_i   (run[1]),
    .mode_i  (mode_eff[1]),
    .pin_i   (cap_even_i),
    .event_o (hit[1])
  );

  // in cascade the odd pin captures both halves together
  assign ev[0]   = hit[0];
  assign ev[1]   = casc ? hit[0] : hit[1]; // R2 R18
  assign push    = ev;
  assign fifo_d[0] = cnt_q[0]; // R22
  assign fifo_d[1] = cnt_q[1]; // R22

  // buffers are never flushed by a mode change; software drains them first
  icp_fifo u_fifo_odd (
    .mclk_i      (mclk_i),
    .rst_n_i     (rst_n_i),
    .flush_i     (1'b0),
    .push_i      (push[0]),
    .data_i      (fifo_d[0]),
    .pop_i       (rd_ev[0]),
    .head_o      (head[0]),
    .not_empty_o (bne[0])
  );

  icp_fifo u_fifo_even (
    .mclk_i      (mclk_i),
    .rst_n_i     (rst_n_i),
    .flush_i     (1'b0),
    .push_i      (push[1]),
    .data_i      (fifo_d[1]),
    .pop_i       (rd_ev[1]),
    .head_o      (head[1]),
    .not_empty_o (bne[1])
  );

  // interrupt decimation: every (field+1)th capture event
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      icnt_q[0] <= '0;
      icnt_q[1] <= '0;
    end else begin
      for (int m = 0; m < 2; m++) begin
        if (!run[m]) begin
          icnt_q[m] <= '0;
        end else if (ev[m]) begin
          icnt_q[m] <= (icnt_q[m] == ifreq[m]) ? '0 : icnt_q[m] + 1'b1; // R7
        end
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_odd_o  <= 1'b0;
      irq_even_o <= 1'b0;
    end else begin
      irq_odd_o  <= ev[0] && (icnt_q[0] == ifreq[0]); // R7
      irq_even_o <= !casc && ev[1] && (icnt_q[1] == ifreq[1]); // R18
    end
  end

  // read data, one cycle after the strobe; bne is live hardware state
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= '0;
    end else if (rd_i) begin
      case (addr_i)
        OFS_ODD_CTRL1:  rdata_o <= c1_q[0] | (16'(bne[0]) << C1_BNE); // R8
        OFS_ODD_CTRL2:  rdata_o <= c2_q[0];
        OFS_ODD_BUF:    rdata_o <= head[0]; // R21
        OFS_EVEN_CTRL1: rdata_o <= c1_q[1] | (16'(bne[1]) << C1_BNE); // R8
        OFS_EVEN_CTRL2: rdata_o <= c2_q[1];
        OFS_EVEN_BUF:   rdata_o <= head[1]; // R21
        default:        rdata_o <= '0;
      endcase
    end else begin
      rdata_o <= '0;
    end
  end
endmodule

//--- testbench/icp_props.sv
// checker: port-level properties of the capture pair
`timescale 1ns/1ps
module icp_props
  import icp_pkg::*;
(
  // clock, reset and register port
  input wire logic        mclk_i,
  input wire logic        rst_n_i,
  input wire logic [2:0]  addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [15:0] rdata_o,
  // capture side
  input wire logic [31:0] sync_src_i,
  input wire logic        cap_odd_i,
  input wire logic        irq_odd_o,
  input wire logic        irq_even_o
);
  logic seen_q;
  // remembers that some sync source has been enabled since reset
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i)
      seen_q <= 1'b0;
    else if (|sync_src_i[31:1])
      seen_q <= 1'b1;
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_wr(a);
    wr_i && addr_i == a;
  endsequence
  sequence s_rd(a);
    rd_i && addr_i == a;
  endsequence
  a_rd_quiet: assert property (!rd_i |=> rdata_o == 16'h0000)
    else $error("read data outside its slot");
  a_odd_cause: assert property (irq_odd_o |-> $past(cap_odd_i, 2) != $past(cap_odd_i))
    else $error("odd interrupt without pin edge");
  a_src_first: assert property ((irq_odd_o || irq_even_o) |-> seen_q)
    else $error("interrupt before any source enabled");
  a_c1_resv: assert property (s_rd(OFS_ODD_CTRL1) |=>
    (rdata_o & ~(C1_WMASK | 16'h0008)) == 16'h0000)
    else $error("control one reserved bits set");
  a_c2_resv: assert property (s_rd(OFS_ODD_CTRL2) |=> (rdata_o & ~C2_WMASK) == 16'h0000)
    else $error("control two reserved bits set");
  a_c2e_resv: assert property (s_rd(OFS_EVEN_CTRL2) |=> (rdata_o & ~C2_WMASK) == 16'h0000)
    else $error("even control two reserved bits set");
  a_c1_back: assert property (s_wr(OFS_ODD_CTRL1) ##1 s_rd(OFS_ODD_CTRL1) |=>
    rdata_o[12:10] == $past(wdata_i[12:10], 2) && rdata_o[6:5] == $past(wdata_i[6:5], 2))
    else $error("control one fields not kept");
  a_c2_back: assert property (s_wr(OFS_ODD_CTRL2) ##1 s_rd(OFS_ODD_CTRL2) |=>
    rdata_o[8:7] == $past(wdata_i[8:7], 2))
    else $error("cascade or trigger bit not kept");
endmodule

bind icp_top icp_props u_icp_props (
  .mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .rd_i(rd_i), .rdata_o(rdata_o), .sync_src_i(sync_src_i), .cap_odd_i(cap_odd_i),
  .irq_odd_o(irq_odd_o), .irq_even_o(irq_even_o));

//--- testbench/icp_edge_src.sv
// partner: square wave on a capture pin while enabled, low otherwise
`timescale 1ns/1ps
module icp_edge_src (
  input  wire logic        mclk_i,
  input  wire logic        go_i,
  input  wire logic [15:0] half_i,
  output logic             pin_o
);
  logic [15:0] cnt_q;
  always @(posedge mclk_i) begin
    if (!go_i) begin
      pin_o <= 1'b0;
      cnt_q <= 16'h0001;
    end else if (cnt_q == half_i) begin
      pin_o <= ~pin_o;
      cnt_q <= 16'h0001;
    end else
      cnt_q <= cnt_q + 16'h0001;
  end
endmodule

//--- testbench/test_icp_top.sv
// testbench: capture pair driven by a square-wave partner on the odd pin
`timescale 1ns/1ps
module test_icp_top;
  import icp_pkg::*;
  logic        mclk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [2:0]  addr_i = 3'h0;
  logic [15:0] wdata_i = 16'h0000;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic [15:0] rdata_o;
  logic [7:0]  tb_tick_i = 8'h01;
  logic [31:0] sync_src_i = 32'h0;
  logic        cap_odd_i;
  logic        cap_even_i = 1'b0;
  logic        irq_odd_o;
  logic        irq_even_o;
  logic        go = 1'b0;
  logic [15:0] half = 16'h0003;
  logic [15:0] q;
  logic [15:0] wd;
  logic [2:0]  a;
  logic [31:0] v [8];
  logic [2:0]  md [5] = '{ICP_EVERY, ICP_RISE, ICP_FALL, ICP_PRE4, ICP_PRE16};
  int          nr [5] = '{2, 3, 4, 15, 63};
  int          sp [5] = '{3, 6, 6, 24, 96};
  integer      seed = 32'h893d75e5;
  int          fail_count = 0;
  int          checks_done = 0;
  int          n_irq;
  int          n_got;
  int          n_ev;
  int          ke;
  always #12.5 mclk_i = ~mclk_i;
  always @(posedge mclk_i) cap_even_i <= go & ~cap_even_i;
  // interrupts expected from n events at decimation field f
  function automatic int exp_irq(input int n, input int f);
    return n / (f + 1);
  endfunction
  icp_top u_icp_top (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .tb_tick_i(tb_tick_i), .sync_src_i(sync_src_i),
    .cap_odd_i(cap_odd_i), .cap_even_i(cap_even_i), .irq_odd_o(irq_odd_o),
    .irq_even_o(irq_even_o));
  icp_edge_src u_icp_edge_src (.mclk_i(mclk_i), .go_i(go), .half_i(half), .pin_o(cap_odd_i));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic do_reset();
    rst_n_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    @(posedge mclk_i);
  endtask
  // optional write, then a read of the same index; q holds the read data
  task automatic rw(input logic [2:0] ad, input logic [15:0] d, input logic w);
    addr_i <= ad;
    wdata_i <= d;
    wr_i <= w;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    @(posedge mclk_i);
    q = rdata_o;
  endtask
  task automatic edges(input int n, input logic [15:0] h);
    int k;
    logic p;
    logic pe;
    k = 0;
    p = 1'b0;
    pe = 1'b0;
    ke = 0;
    n_irq = 0;
    n_ev = 0;
    half <= h;
    go <= 1'b1;
    while (k < n) begin
      @(posedge mclk_i);
      n_irq += irq_odd_o;
      n_ev += irq_even_o;
      k += cap_odd_i & ~p;
      p = cap_odd_i;
      ke += cap_even_i & ~pe;
      pe = cap_even_i;
    end
    go <= 1'b0;
    repeat (4) begin
      @(posedge mclk_i);
      n_irq += irq_odd_o;
      n_ev += irq_even_o;
    end
  endtask
  task automatic drain();
    logic [15:0] lo;
    n_got = 0;
    rw(OFS_ODD_CTRL1, 16'h0000, 1'b0);
    while (q[C1_BNE] === 1'b1 && n_got < 8) begin
      rw(OFS_ODD_BUF, 16'h0000, 1'b0);
      lo = q;
      rw(OFS_EVEN_BUF, 16'h0000, 1'b0);
      v[n_got] = {q, lo};
      n_got++;
      rw(OFS_ODD_CTRL1, 16'h0000, 1'b0);
    end
  endtask
  initial begin
    do_reset();
    for (int i = 0; i < 7; i++) begin
      rw(i[2:0], 16'h0000, 1'b0);
      chk(q, 32'h0);
    end
    for (int i = 0; i < 8; i++) begin
      a = {i[1], 1'b0, i[0]};
      wd = (i < 4) ? 16'hFEFF : 16'($random(seed)) & 16'hFEFF;
      rw(a, wd, 1'b1);
      chk(q, wd & (a[0] ? C2_WMASK : C1_WMASK));
    end
    do_reset();
    rw(OFS_ODD_CTRL2, 16'h0001, 1'b1);
    rw(OFS_ODD_CTRL1, 16'h0003, 1'b1);
    sync_src_i <= 32'h2;
    for (int m = 0; m < 5; m++) begin
      rw(OFS_ODD_CTRL1, {13'h0, md[m]}, 1'b1);
      edges(nr[m], 16'h0003);
      drain();
      chk(v[1] - v[0], sp[m]);
      chk(v[2] - v[1], sp[m]);
      if (m == 1)
        chk(n_irq, 3);
    end
    for (int f = 1; f < 4; f += 2) begin
      rw(OFS_ODD_CTRL1, 16'h0003 | 16'(f << C1_IFREQ_LO), 1'b1);
      edges(8, 16'h0003);
      chk(n_irq, exp_irq(8, f));
      drain();
      chk(n_got, FIFO_DEPTH);
    end
    rw(OFS_EVEN_CTRL2, 16'h0001, 1'b1);
    rw(OFS_EVEN_CTRL1, 16'h0003, 1'b1);
    edges(4, 16'h0003);
    chk(n_ev, ke);
    drain();
    chk(v[1][31:16] - v[0][31:16], 32'h2);
    chk(v[2][31:16] - v[1][31:16], 32'h2);
    rw(OFS_ODD_CTRL2, 16'h0081, 1'b1);
    rw(OFS_ODD_CTRL2, 16'h0081, 1'b1);
    chk(q, 32'h00C1);
    sync_src_i <= 32'h0;
    do_reset();
    rw(OFS_EVEN_CTRL2, 16'h0101, 1'b1);
    rw(OFS_ODD_CTRL2, 16'h0101, 1'b1);
    rw(OFS_ODD_CTRL1, 16'h0003, 1'b1);
    sync_src_i <= 32'h2;
    repeat (65520) @(posedge mclk_i);
    edges(3, 16'h0008);
    chk(n_ev, 0);
    drain();
    chk(v[1] - v[0], 32'h10);
    chk(v[2] - v[1], 32'h10);
    chk(v[0][31:16], 32'h0);
    chk(v[2][31:16], 32'h1);
    final_report();
  end
  initial begin
    #(90000 * 25);
    fail_count++;
    final_report();
  end
endmodule
